// ===== sent_payload_pkg.sv
package sent_payload_pkg;

    // Stored-word locations, kept as indices.
    localparam logic [7:0] CUSTOMER_IDENTIFIER_OFFSET = 8'h02;
    localparam logic [7:0] ERROR_STATUS_OFFSET = 8'h45;

    // Byte positions inside the stored words.
    localparam int ERROR_BYTE_LSB = 16;
    localparam int CUSTOMER_BYTE0_LSB = 0;
    localparam int CUSTOMER_BYTE1_LSB = 8;
    localparam int CUSTOMER_BYTE2_LSB = 16;

    // Status nibble bit positions.
    localparam int STATUS_START_BIT = 3;
    localparam int STATUS_SERIAL_BIT = 2;
    localparam int STATUS_SOFT_BIT = 1;
    localparam int STATUS_HARD_BIT = 0;

    // Data layouts.
    localparam logic [1:0] LAYOUT_SHORT = 2'h0;
    localparam logic [1:0] LAYOUT_DIAG = 2'h1;
    localparam logic [1:0] LAYOUT_COUNT = 2'h2;
    localparam logic [1:0] LAYOUT_TEMP = 2'h3;
    localparam logic [2:0] DATA_NIBBLES_SHORT = 3'h3;
    localparam logic [2:0] DATA_NIBBLES_LONG = 3'h6;

    // Frame counter limits.
    localparam logic [11:0] COUNT_MAX_DIAG = 12'h00f;
    localparam logic [11:0] COUNT_STEP = 12'h001;

    // Short serial message sequence.
    localparam logic [3:0] SSM_FRAME_LAST = 4'hf;
    localparam logic [3:0] SSM_ID_FIRST = 4'h0;
    localparam logic [3:0] SSM_ID_LAST = 4'h4;

    // Check nibble generator x^4 + x^3 + x^2 + 1 and its seed.
    localparam logic [3:0] CRC_SEED = 4'h5;
    localparam logic [3:0] CRC_POLY = 4'hd;

    // Nibble timing in ticks.
    localparam logic [4:0] NIBBLE_LOW_TICKS = 5'h05;
    localparam logic [4:0] NIBBLE_MIN_TICKS = 5'h0c;

    // Nibble kinds on the stream.
    localparam logic [1:0] KIND_STATUS = 2'h0;
    localparam logic [1:0] KIND_DATA = 2'h1;
    localparam logic [1:0] KIND_CRC = 2'h2;

    // Stream buffer shape.
    localparam int ENTRY_WIDTH = 12;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EMIT = 3'b010,
        ST_CRC = 3'b100
    } build_state_type;

    function automatic logic [3:0] crc4_step(input logic [3:0] crc, input logic [3:0] nib);
        logic [3:0] c;
        logic fb;
        c = crc;
        for (int i = 3; i >= 0; i--) begin
            fb = c[3] ^ nib[i];
            c = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
        end
        return c;
    endfunction

endpackage

// ===== sent_nibble_fifo.sv
`timescale 1ns/1ps
module sent_nibble_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Filling side.
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Draining side.
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic out_valid_reg;
    logic push;
    logic pop;

    assign in_ready = count_reg < (AW+1)'(DEPTH);
    assign push = in_valid && in_ready;
    assign pop = (count_reg != '0) && (!out_valid_reg || out_ready);
    assign out_data = out_data_reg;
    assign out_valid = out_valid_reg;

    // Storage is written only, so it needs no reset.
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered output stage holds one word beyond the array.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_data_reg <= '0;
            out_valid_reg <= 1'b0;
        end else if (pop) begin
            out_data_reg <= mem[rd_ptr_reg];
            out_valid_reg <= 1'b1;
        end else if (out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    fifo_count_a: assert property (@(posedge clock) disable iff (rst)
        count_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

// ===== sent_frame_payload_builder.sv
`timescale 1ns/1ps
module sent_frame_payload_builder
    import sent_payload_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Configuration.
    input wire logic short_serial_disable,
    input wire logic address_in_status_nibble,
    input wire logic sequential_polled_mode,
    input wire logic addressed_polled_mode,
    input wire logic [1:0] bus_address,
    input wire logic [1:0] data_nibble_layout,
    input wire logic crc_covers_status,
    // Measurements.
    input wire logic [11:0] field_value,
    input wire logic [11:0] temperature_word,
    input wire logic [7:0] temperature_byte,
    // Diagnostics.
    input wire logic overvoltage,
    input wire logic undervoltage,
    input wire logic overtemperature,
    input wire logic range_low,
    input wire logic range_high,
    input wire logic coil_self_test_error,
    input wire logic logic_self_test_error,
    input wire logic nonvolatile_memory_error,
    // Stored words.
    input wire logic [23:0] customer_identifier_word,
    input wire logic [23:0] error_status_word,
    // Frame request.
    input wire logic frame_request,
    output logic frame_busy,
    // Nibble stream.
    output logic [3:0] nibble_value,
    output logic [1:0] nibble_kind,
    output logic nibble_last,
    output logic [4:0] nibble_ticks,
    output logic nibble_valid,
    input wire logic nibble_ready,
    // Sequence state.
    output logic [3:0] message_id,
    output logic [11:0] frame_count
);
    if (DEPTH < 8) begin : g_bad_depth
        $error("DEPTH must hold at least one whole frame");
    end

    build_state_type state_reg;
    logic busy_reg;
    logic [3:0] payload_reg [7];
    logic [2:0] last_idx_reg;
    logic [2:0] idx_reg;
    logic [3:0] crc_reg;
    logic [11:0] count_reg;
    logic [3:0] ssm_frame_reg;
    logic [3:0] msg_id_reg;
    logic [15:0] ssm_word_reg;

    logic accept;
    logic ssm_on;
    logic addr_on;
    logic soft_error;
    logic [7:0] diag_byte;
    logic [7:0] ssm_byte;
    logic [3:0] ssm_crc;
    logic [15:0] ssm_word_next;
    logic serial_bit;
    logic [3:0] status_next;
    logic [3:0] data_next [6];
    logic [2:0] last_idx_next;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic push;
    logic [3:0] push_value;
    logic [1:0] push_kind;
    logic push_last;
    logic [ENTRY_WIDTH-1:0] fifo_in_data;
    logic [ENTRY_WIDTH-1:0] fifo_out_data;

    assign accept = frame_request && (state_reg == ST_IDLE);
    assign ssm_on = !short_serial_disable;
    assign addr_on = short_serial_disable && address_in_status_nibble
        && (sequential_polled_mode || addressed_polled_mode);
    assign soft_error = overvoltage | undervoltage | overtemperature
        | range_low | range_high;
    assign diag_byte = {nonvolatile_memory_error, logic_self_test_error,
        coil_self_test_error, undervoltage, overvoltage, overtemperature,
        range_low, range_high};

    // Data byte of the short message for the current ID.
    always_comb begin
        case (msg_id_reg)
            4'h0: ssm_byte = error_status_word[ERROR_BYTE_LSB +: 8];
            4'h1: ssm_byte = temperature_byte;
            4'h2: ssm_byte = customer_identifier_word[CUSTOMER_BYTE0_LSB +: 8];
            4'h3: ssm_byte = customer_identifier_word[CUSTOMER_BYTE1_LSB +: 8];
            default: ssm_byte = customer_identifier_word[CUSTOMER_BYTE2_LSB +: 8];
        endcase
    end

    assign ssm_crc = crc4_step(crc4_step(crc4_step(CRC_SEED, msg_id_reg),
        ssm_byte[7:4]), ssm_byte[3:0]);
    assign ssm_word_next = {msg_id_reg, ssm_byte, ssm_crc};

    // The first frame of a message sends from the fresh word.
    assign serial_bit = (ssm_frame_reg == 4'h0) ? ssm_word_next[15]
        : ssm_word_reg[SSM_FRAME_LAST - ssm_frame_reg];

    // Status and communication nibble.
    always_comb begin
        status_next = 4'h0;
        status_next[STATUS_SOFT_BIT] = soft_error;
        status_next[STATUS_HARD_BIT] = coil_self_test_error;
        if (ssm_on) begin
            status_next[STATUS_START_BIT] = (ssm_frame_reg == 4'h0);
            status_next[STATUS_SERIAL_BIT] = serial_bit;
        end else if (addr_on) begin
            status_next[STATUS_START_BIT] = bus_address[1];
            status_next[STATUS_SERIAL_BIT] = bus_address[0];
        end
    end

    // Data nibbles for the selected layout.
    always_comb begin
        data_next[0] = field_value[11:8];
        data_next[1] = field_value[7:4];
        data_next[2] = field_value[3:0];
        data_next[3] = 4'h0;
        data_next[4] = 4'h0;
        data_next[5] = 4'h0;
        last_idx_next = DATA_NIBBLES_LONG;
        case (data_nibble_layout)
            LAYOUT_SHORT: begin
                last_idx_next = DATA_NIBBLES_SHORT;
            end
            LAYOUT_DIAG: begin
                data_next[3] = diag_byte[7:4];
                data_next[4] = diag_byte[3:0];
                data_next[5] = count_reg[3:0];
            end
            LAYOUT_COUNT: begin
                data_next[3] = count_reg[11:8];
                data_next[4] = count_reg[7:4];
                data_next[5] = count_reg[3:0];
            end
            default: begin
                data_next[3] = temperature_word[11:8];
                data_next[4] = temperature_word[7:4];
                data_next[5] = temperature_word[3:0];
            end
        endcase
    end

    // Frame build sequence: status, data, then check nibble.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            idx_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        state_reg <= ST_EMIT;
                        busy_reg <= 1'b1;
                        idx_reg <= 3'h0;
                    end
                end
                ST_EMIT: begin
                    if (push) begin
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg == last_idx_reg) begin
                            state_reg <= ST_CRC;
                        end
                    end
                end
                ST_CRC: begin
                    if (push) begin
                        state_reg <= ST_IDLE;
                        busy_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // Nibbles of the frame are frozen when the frame is accepted.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 7; i++) begin
                payload_reg[i] <= 4'h0;
            end
            last_idx_reg <= 3'h0;
        end else if (accept) begin
            payload_reg[0] <= status_next;
            for (int i = 0; i < 6; i++) begin
                payload_reg[i + 1] <= data_next[i];
            end
            last_idx_reg <= last_idx_next;
        end
    end

    // Check nibble runs along the data in send order.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            crc_reg <= CRC_SEED;
        end else if (accept) begin
            crc_reg <= crc_covers_status ? crc4_step(CRC_SEED, status_next) : CRC_SEED;
        end else if (push && state_reg == ST_EMIT && idx_reg != 3'h0) begin
            crc_reg <= crc4_step(crc_reg, payload_reg[idx_reg]);
        end
    end

    // Frame counter steps once per frame.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= 12'h000;
        end else if (accept) begin
            if (data_nibble_layout == LAYOUT_DIAG && count_reg >= COUNT_MAX_DIAG) begin
                count_reg <= 12'h000;
            end else begin
                count_reg <= count_reg + COUNT_STEP;
            end
        end
    end

    // Short message sequencing across frames.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ssm_frame_reg <= 4'h0;
            msg_id_reg <= SSM_ID_FIRST;
            ssm_word_reg <= 16'h0000;
        end else if (accept) begin
            if (!ssm_on) begin
                ssm_frame_reg <= 4'h0;
            end else if (ssm_frame_reg == SSM_FRAME_LAST) begin
                ssm_frame_reg <= 4'h0;
                msg_id_reg <= (msg_id_reg >= SSM_ID_LAST) ? SSM_ID_FIRST
                    : msg_id_reg + 4'h1;
            end else begin
                ssm_frame_reg <= ssm_frame_reg + 4'h1;
            end
            if (ssm_on && ssm_frame_reg == 4'h0) begin
                ssm_word_reg <= ssm_word_next;
            end
        end
    end

    // Stream entry: value, kind, last flag and nibble length in ticks.
    always_comb begin
        fifo_in_valid = 1'b0;
        push_value = 4'h0;
        push_kind = KIND_DATA;
        push_last = 1'b0;
        if (state_reg == ST_EMIT) begin
            fifo_in_valid = 1'b1;
            push_value = payload_reg[idx_reg];
            push_kind = (idx_reg == 3'h0) ? KIND_STATUS : KIND_DATA;
        end else if (state_reg == ST_CRC) begin
            fifo_in_valid = 1'b1;
            push_value = crc_reg;
            push_kind = KIND_CRC;
            push_last = 1'b1;
        end
    end

    assign push = fifo_in_valid && fifo_in_ready;
    assign fifo_in_data = {push_value, push_kind, push_last,
        NIBBLE_MIN_TICKS + {1'b0, push_value}};

    sent_nibble_fifo #(
        .WIDTH(ENTRY_WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_data(fifo_in_data),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(nibble_valid),
        .out_ready(nibble_ready)
    );

    assign nibble_value = fifo_out_data[11:8];
    assign nibble_kind = fifo_out_data[7:6];
    assign nibble_last = fifo_out_data[5];
    assign nibble_ticks = fifo_out_data[4:0];
    assign frame_busy = busy_reg;
    assign message_id = msg_id_reg;
    assign frame_count = count_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    ssm_off_a: assert property (accept && !ssm_on && !addr_on
        |=> payload_reg[0][3:2] == 2'b00) else $error("serial bits used while disabled");
    msg_wrap_a: assert property (accept && ssm_on && ssm_frame_reg == 4'hf
        && msg_id_reg == 4'h4 |=> msg_id_reg == 4'h0) else $error("message ID did not wrap");
    start_bit_a: assert property (accept && ssm_on
        |=> payload_reg[0][3] == $past(ssm_frame_reg == 4'h0)) else $error("bad start bit");
    soft_flag_a: assert property (accept
        |=> payload_reg[0][1] == $past(soft_error)) else $error("soft flag wrong");
    hard_flag_a: assert property (accept
        |=> payload_reg[0][0] == $past(coil_self_test_error)) else $error("hard flag wrong");
    address_bits_a: assert property (accept && addr_on
        |=> payload_reg[0][3:2] == $past(bus_address)) else $error("address bits wrong");
    data_length_a: assert property (accept |=> last_idx_reg
        == ($past(data_nibble_layout) == 2'h0 ? 3'h3 : 3'h6)) else $error("bad data length");
    field_first_a: assert property (accept
        |=> payload_reg[1] == $past(field_value[11:8])) else $error("field nibble wrong");
    count_wrap_a: assert property (accept && data_nibble_layout == 2'h1
        && count_reg == 12'h00f |=> count_reg == 12'h000) else $error("counter did not wrap");
    crc_seed_a: assert property (accept && !crc_covers_status
        |=> crc_reg == 4'h5) else $error("check seed wrong");
    frame_order_a: assert property (push && push_kind == KIND_STATUS
        |=> state_reg == ST_EMIT ##0 idx_reg == 3'h1) else $error("status not first");

    long_frame_c: cover property (accept && data_nibble_layout == 2'h2 ##[1:20] push_last);
    message_wrap_c: cover property (accept && ssm_on && msg_id_reg == 4'h4
        && ssm_frame_reg == 4'hf);
    stream_stall_c: cover property (fifo_in_valid && !fifo_in_ready);

endmodule

// ===== frame_sink.sv
`timescale 1ns/1ps
module frame_sink (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Stream from the builder.
    input wire logic [3:0] nibble_value,
    input wire logic [1:0] nibble_kind,
    input wire logic nibble_last,
    input wire logic [4:0] nibble_ticks,
    input wire logic nibble_valid,
    output logic nibble_ready,
    // Pacing.
    input wire logic hold,
    input wire logic slow
);
    // Words taken, packed as ticks, kind, last flag and value.
    logic [11:0] got[$];

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            nibble_ready <= 1'b0;
            got.delete();
        end else begin
            if (nibble_valid && nibble_ready) begin
                got.push_back({nibble_ticks, nibble_kind, nibble_last, nibble_value});
            end
            nibble_ready <= !hold && (!slow || ($urandom % 3 != 0));
        end
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import sent_payload_pkg::*;
    logic clock, rst, ssd, ain, seqm, adm, crc_st, frame_request, hold, slow;
    logic [1:0] bus_address, layout, nibble_kind;
    logic [11:0] field_value, temperature_word, frame_count, cnt;
    logic [7:0] temperature_byte, flags;
    logic [23:0] cust_word, err_word;
    logic frame_busy, nibble_last, nibble_valid, nibble_ready;
    logic [3:0] nibble_value, message_id, mid;
    logic [4:0] nibble_ticks;
    logic [15:0] word;
    logic [11:0] exp_q[$];
    int err_total, samples_checked, k;

    sent_frame_payload_builder dut (.clock(clock), .rst(rst), .short_serial_disable(ssd),
        .address_in_status_nibble(ain), .sequential_polled_mode(seqm),
        .addressed_polled_mode(adm), .bus_address(bus_address), .data_nibble_layout(layout),
        .crc_covers_status(crc_st), .field_value(field_value),
        .temperature_word(temperature_word), .temperature_byte(temperature_byte),
        .overvoltage(flags[3]), .undervoltage(flags[4]), .overtemperature(flags[2]),
        .range_low(flags[1]), .range_high(flags[0]), .coil_self_test_error(flags[5]),
        .logic_self_test_error(flags[6]), .nonvolatile_memory_error(flags[7]),
        .customer_identifier_word(cust_word), .error_status_word(err_word),
        .frame_request(frame_request), .frame_busy(frame_busy), .nibble_value(nibble_value),
        .nibble_kind(nibble_kind), .nibble_last(nibble_last), .nibble_ticks(nibble_ticks),
        .nibble_valid(nibble_valid), .nibble_ready(nibble_ready), .message_id(message_id),
        .frame_count(frame_count));

    frame_sink sink (.clock(clock), .rst(rst), .nibble_value(nibble_value),
        .nibble_kind(nibble_kind), .nibble_last(nibble_last), .nibble_ticks(nibble_ticks),
        .nibble_valid(nibble_valid), .nibble_ready(nibble_ready), .hold(hold), .slow(slow));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    function automatic logic [3:0] ck(input logic [3:0] c, input logic [3:0] d);
        logic f;
        for (int i = 3; i >= 0; i--) begin
            f = c[3] ^ d[i];
            c = {c[2:0], 1'b0} ^ {f, f, 1'b0, f};
        end
        return c;
    endfunction

    task automatic push(input logic [3:0] v, input logic [1:0] kd, input logic ls);
        exp_q.push_back({5'h0c + {1'b0, v}, kd, ls, v});
    endtask

    // Works out the whole frame from the inputs taken at the accepting edge.
    task automatic expect_frame();
        logic [3:0] st, c;
        logic [3:0] d[6];
        logic [7:0] b;
        int n;
        st = {2'h0, |flags[4:0], flags[5]};
        if (!ssd) begin
            if (k == 0) begin
                b = mid == 4'h0 ? err_word[23:16] : mid == 4'h1 ? temperature_byte :
                    cust_word[8 * (mid - 4'h2) +: 8];
                word = {mid, b, ck(ck(ck(4'h5, mid), b[7:4]), b[3:0])};
            end
            st[3:2] = {k == 0, word[15 - k]};
        end else if (ain && (seqm || adm)) begin
            st[3:2] = bus_address;
        end
        d = '{field_value[11:8], field_value[7:4], field_value[3:0], 4'h0, 4'h0, 4'h0};
        case (layout)
            2'h1: {d[3], d[4], d[5]} = {flags, cnt[3:0]};
            2'h2: {d[3], d[4], d[5]} = cnt;
            2'h3: {d[3], d[4], d[5]} = temperature_word;
            default: ;
        endcase
        n = layout == 2'h0 ? 3 : 6;
        c = crc_st ? ck(4'h5, st) : 4'h5;
        push(st, 2'h0, 1'b0);
        for (int i = 0; i < n; i++) begin
            push(d[i], 2'h1, 1'b0);
            c = ck(c, d[i]);
        end
        push(c, 2'h2, 1'b1);
        cnt = ((layout == 2'h1 && cnt >= 12'h00f) || cnt == 12'hfff) ? 12'h000 : cnt + 12'h001;
        if (!ssd) begin
            k++;
            if (k == 16) begin
                k = 0;
                mid = (mid == 4'h4) ? 4'h0 : mid + 4'h1;
            end
        end else begin
            k = 0;
        end
    endtask

    task automatic accept_frame(input int lay);
        logic [31:0] r;
        int i;
        i = 0;
        while (frame_busy !== 1'b0 && i < 3000) begin
            @(posedge clock);
            i++;
        end
        if (i == 3000) begin
            chk(1'b0, "builder stuck busy");
            wrap_up();
        end
        @(posedge clock);
        r = $urandom;
        field_value <= r[11:0];
        temperature_word <= r[23:12];
        temperature_byte <= r[31:24];
        r = $urandom;
        cust_word <= r[23:0];
        flags <= r[31:24];
        r = $urandom;
        err_word <= r[23:0];
        {ain, seqm, adm, crc_st, bus_address} <= r[29:24];
        layout <= lay < 0 ? r[31:30] : lay[1:0];
        frame_request <= 1'b1;
        @(posedge clock);
        expect_frame();
        // Still high at the next edge while busy, so it must be ignored.
        @(posedge clock);
        frame_request <= 1'b0;
    endtask

    task automatic drain();
        int i;
        i = 0;
        while ((frame_busy !== 1'b0 || sink.got.size() < exp_q.size()) && i < 9000) begin
            @(posedge clock);
            i++;
        end
        if (i == 9000) begin
            chk(1'b0, "stream never completed");
            wrap_up();
        end
        chk(sink.got.size() == exp_q.size(), "word count");
        foreach (exp_q[j]) chk(sink.got[j] === exp_q[j], $sformatf("word %0d", j));
        chk(frame_count === cnt && message_id === mid, "sequence state");
        sink.got.delete();
        exp_q.delete();
    endtask

    task automatic run(input int n, input int lay);
        repeat (n) accept_frame(lay);
        drain();
    endtask

    task automatic model_reset();
        k = 0;
        mid = 4'h0;
        cnt = 12'h000;
        exp_q.delete();
    endtask

    initial begin
        {rst, ssd, ain, seqm, adm, crc_st, frame_request, hold, slow} = 9'h100;
        {bus_address, layout, field_value, temperature_word, temperature_byte, flags} = '0;
        {cust_word, err_word} = '0;
        err_total = 0;
        samples_checked = 0;
        model_reset();
        void'($urandom(16));
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk(frame_busy === 1'b0 && nibble_valid === 1'b0 && message_id === 4'h0
            && frame_count === 12'h000, "reset state");
        slow <= 1'b1;
        run(100, -1);
        $display("test serial done");
        ssd <= 1'b1;
        run(40, -1);
        $display("test polled done");
        slow <= 1'b0;
        hold <= 1'b1;
        ssd <= 1'b0;
        accept_frame(0);
        accept_frame(1);
        accept_frame(1);
        repeat (40) @(posedge clock);
        chk(frame_busy === 1'b1 && nibble_valid === 1'b1 && nibble_kind === KIND_STATUS,
            "no stall with full buffer");
        hold <= 1'b0;
        drain();
        $display("test fill done");
        ssd <= 1'b1;
        run(4100, 2);
        $display("test wrap done");
        ssd <= 1'b0;
        accept_frame(-1);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        model_reset();
        @(posedge clock);
        chk(frame_busy === 1'b0 && nibble_valid === 1'b0 && message_id === 4'h0
            && frame_count === 12'h000, "second reset state");
        run(20, -1);
        // Seventeen diagnostic frames always pass the count of 15 and wrap.
        run(17, 1);
        $display("test reset done");
        wrap_up();
    end
endmodule
